// ===== core/psic_defines.svh
// psic_defines.svh: sizes, reset values and fixed counts of the issue core
`ifndef PSIC_DEFINES_SVH
`define PSIC_DEFINES_SVH
`define PSIC_NUM_GR 128
`define PSIC_NUM_FR 128
`define PSIC_NUM_PR 64
`define PSIC_NUM_BR 8
`define PSIC_SLOTS 3
`define PSIC_STATIC_GR 7'h20
`define PSIC_STACK_GR 8'h60
`define PSIC_FSTK_AW 4
`define PSIC_ALAT_AW 2
`define PSIC_RST_PRED 64'h0000_0000_0000_0001
`endif

// ===== core/psic_pkg.sv
// psic_pkg: operation and state types of the issue core
`default_nettype none
package psic_pkg;
    typedef enum logic [3:0] {
        OP_NOP, OP_WRITE, OP_CMP, OP_CMP_UNC, OP_CMP_AND, OP_CMP_OR, OP_LD, OP_LD_S,
        OP_LD_A, OP_ST, OP_CHK_S, OP_CHK_A, OP_ALLOC, OP_CALL, OP_RET
    } psic_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ALLOC, ST_POP, ST_RET} psic_state_t;
endpackage : psic_pkg
`default_nettype wire

// ===== core/psic_frame_mem.sv
// psic_frame_mem: stack of caller frame sizes, registered read
`default_nettype none
`include "psic_defines.svh"
module psic_frame_mem (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_we,
    input wire logic [`PSIC_FSTK_AW-1:0] i_waddr,
    input wire logic [6:0] i_wdata,
    input wire logic i_re,
    input wire logic [`PSIC_FSTK_AW-1:0] i_raddr,
    output logic [6:0] o_rdata
);
    logic [6:0] mem [1<<`PSIC_FSTK_AW];

    always_ff @(posedge i_clk_sys) begin
        if (i_ce && i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else if (i_ce && i_re) begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule : psic_frame_mem
`default_nettype wire

// ===== core/psic_core.sv
// psic_core: predicated bundle issue, speculation checks and register stack control
`default_nettype none
`include "psic_defines.svh"
// What this block does
// RULE_01: holds 128 integer, 128 float, 64 predicate, 8 branch register resources; the block keeps no float or branch registers.
// RULE_02: takes three independent slots per bundle and handles them in one cycle; the block takes stack ops from slot 0 only.
// RULE_03: every load and store passes its two-bit locality hint to memory.
// RULE_04: faulting speculative load defers; its check branches to recovery only if marked.
// RULE_05: advanced load check recovers when a later store overlapped its address.
// RULE_06: an instruction changes state only when its qualifying predicate is true; OP_CMP_UNC still writes both its predicates, to zero, when it is false.
// RULE_07: compare writes condition to first predicate and its complement to the second.
// RULE_08: unconditional, and-type and or-type compares write predicates differently.
// RULE_09: register numbers are renamed into physical registers through the frame base.
// RULE_10: a call hands the callee a fresh frame without software saves.
// RULE_11: frame allocation stalls and spills caller registers until the request fits.
// RULE_12: return restores the frame base the caller used before the call.
// RULE_13: return stalls until enough spilled caller registers are filled back.
// RULE_14: idle cycles refill spilled registers on their own using frame bookkeeping.
// RULE_15: deferred fault is a per-register marker tested by the later check.
module psic_core
    import psic_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_bnd_valid,
    input wire psic_op_t i_slot_op [`PSIC_SLOTS],
    input wire logic [`PSIC_SLOTS-1:0][5:0] i_slot_qp,
    input wire logic [`PSIC_SLOTS-1:0][5:0] i_slot_p1,
    input wire logic [`PSIC_SLOTS-1:0][5:0] i_slot_p2,
    input wire logic [`PSIC_SLOTS-1:0][6:0] i_slot_reg,
    input wire logic [`PSIC_SLOTS-1:0] i_slot_cond,
    input wire logic [`PSIC_SLOTS-1:0] i_slot_fault,
    input wire logic [`PSIC_SLOTS-1:0][1:0] i_slot_hint,
    input wire logic [`PSIC_SLOTS-1:0][15:0] i_slot_addr,
    input wire logic i_rse_ack,
    output logic o_bnd_ready,
    output logic [`PSIC_NUM_PR-1:0] o_pred,
    output logic [`PSIC_SLOTS-1:0] o_wr_valid,
    output logic [`PSIC_SLOTS-1:0][6:0] o_wr_phys,
    output logic [`PSIC_SLOTS-1:0] o_mem_valid,
    output logic [`PSIC_SLOTS-1:0] o_mem_store,
    output logic [`PSIC_SLOTS-1:0][1:0] o_mem_hint,
    output logic [`PSIC_SLOTS-1:0][15:0] o_mem_addr,
    output logic o_fault,
    output logic o_recover,
    output logic [1:0] o_recover_slot,
    output logic o_rse_req,
    output logic o_rse_spill,
    output logic [6:0] o_rse_idx,
    output logic [6:0] o_bof,
    output logic [6:0] o_sof
);
    // =========================================================================
    // helpers
    function automatic logic [6:0] wrap96(input logic [7:0] x);
        return (x >= `PSIC_STACK_GR) ? 7'(x - `PSIC_STACK_GR) : x[6:0];
    endfunction : wrap96

    function automatic logic [6:0] phys_of(input logic [6:0] v, input logic [6:0] b);
        if (v < `PSIC_STATIC_GR) begin
            return v;
        end
        return 7'(`PSIC_STATIC_GR + wrap96(8'({1'b0, b} + {1'b0, v} - {1'b0, `PSIC_STATIC_GR})));
    endfunction : phys_of

    function automatic logic is_load(input psic_op_t op);
        return op == OP_LD || op == OP_LD_S || op == OP_LD_A;
    endfunction : is_load

    // =========================================================================
    // state
    logic [`PSIC_NUM_PR-1:0] pred_reg, pred_next;
    logic [`PSIC_NUM_GR-1:0] nat_reg;
    logic [(1<<`PSIC_ALAT_AW)-1:0] alat_v_reg;
    logic [6:0] alat_tag_reg [1<<`PSIC_ALAT_AW];
    logic [15:0] alat_addr_reg [1<<`PSIC_ALAT_AW];
    psic_state_t st_reg;
    logic [6:0] bof_reg, sof_reg, ndirty_reg, want_reg, prev_reg, rse_idx_reg;
    logic [10:0] nspill_reg;
    logic [`PSIC_FSTK_AW-1:0] fsp_reg;
    logic ready_reg, rse_req_reg, rse_spill_reg, fault_reg, recover_reg;
    logic [1:0] recover_slot_reg;
    logic [`PSIC_SLOTS-1:0] wr_valid_reg, mem_valid_reg, mem_store_reg;
    logic [`PSIC_SLOTS-1:0][6:0] wr_phys_reg;
    logic [`PSIC_SLOTS-1:0][1:0] mem_hint_reg;
    logic [`PSIC_SLOTS-1:0][15:0] mem_addr_reg;
    logic accept;
    logic [`PSIC_SLOTS-1:0] exe;
    logic [`PSIC_SLOTS-1:0][6:0] phys;
    logic [7:0] room;
    logic [6:0] fm_rdata;

    assign accept = i_ce && i_bnd_valid && ready_reg;
    assign room = 8'(`PSIC_STACK_GR - {1'b0, ndirty_reg});

    // =========================================================================
    // slot qualification and renaming
    always_comb begin
        for (int s = 0; s < `PSIC_SLOTS; s++) begin
            exe[s] = accept && pred_reg[i_slot_qp[s]]; // [RULE_06] [RULE_02]
            phys[s] = phys_of(i_slot_reg[s], bof_reg); // [RULE_09]
        end
    end

    // =========================================================================
    // predicate file; slot order decides when two compares hit one predicate
    always_comb begin
        pred_next = pred_reg;
        for (int s = 0; s < `PSIC_SLOTS; s++) begin
            if (exe[s] && i_slot_op[s] == OP_CMP) begin
                pred_next[i_slot_p1[s]] = i_slot_cond[s]; // [RULE_07]
                pred_next[i_slot_p2[s]] = !i_slot_cond[s];
            end else if (exe[s] && i_slot_op[s] == OP_CMP_AND && !i_slot_cond[s]) begin
                pred_next[i_slot_p1[s]] = 1'b0; // [RULE_08]
                pred_next[i_slot_p2[s]] = 1'b0;
            end else if (exe[s] && i_slot_op[s] == OP_CMP_OR && i_slot_cond[s]) begin
                pred_next[i_slot_p1[s]] = 1'b1; // [RULE_08]
                pred_next[i_slot_p2[s]] = 1'b1;
            end else if (accept && i_slot_op[s] == OP_CMP_UNC) begin
                // written even with a false qualifier: both come out zero
                pred_next[i_slot_p1[s]] = exe[s] && i_slot_cond[s]; // [RULE_08]
                pred_next[i_slot_p2[s]] = exe[s] && !i_slot_cond[s];
            end
        end
        pred_next[0] = 1'b1;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            pred_reg <= `PSIC_RST_PRED;
        end else if (i_ce) begin
            pred_reg <= pred_next;
        end
    end

    // =========================================================================
    // deferred-fault markers and advanced-load table (direct mapped by register)
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            nat_reg <= '0;
            alat_v_reg <= '0;
        end else if (i_ce) begin
            for (int s = 0; s < `PSIC_SLOTS; s++) begin
                if (exe[s] && (i_slot_op[s] == OP_LD_S)) begin
                    nat_reg[phys[s]] <= i_slot_fault[s]; // [RULE_04] [RULE_15]
                end else if (exe[s] && (i_slot_op[s] == OP_WRITE || is_load(i_slot_op[s]))) begin
                    nat_reg[phys[s]] <= 1'b0;
                end
                if (exe[s] && i_slot_op[s] == OP_ST) begin
                    for (int e = 0; e < (1 << `PSIC_ALAT_AW); e++) begin
                        if (alat_addr_reg[e] == i_slot_addr[s]) begin
                            alat_v_reg[e] <= 1'b0; // [RULE_05]
                        end
                    end
                end
                if (exe[s] && i_slot_op[s] == OP_LD_A) begin
                    alat_v_reg[phys[s][`PSIC_ALAT_AW-1:0]] <= 1'b1;
                    alat_tag_reg[phys[s][`PSIC_ALAT_AW-1:0]] <= phys[s];
                    alat_addr_reg[phys[s][`PSIC_ALAT_AW-1:0]] <= i_slot_addr[s];
                end
            end
        end
    end

    // =========================================================================
    // per-slot results: writes, memory requests, faults and recovery branches
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_valid_reg <= '0;
            wr_phys_reg <= '0;
            mem_valid_reg <= '0;
            mem_store_reg <= '0;
            mem_hint_reg <= '0;
            mem_addr_reg <= '0;
            fault_reg <= 1'b0;
            recover_reg <= 1'b0;
            recover_slot_reg <= 2'h0;
        end else if (i_ce) begin
            fault_reg <= 1'b0;
            recover_reg <= 1'b0;
            for (int s = `PSIC_SLOTS - 1; s >= 0; s--) begin
                wr_valid_reg[s] <= exe[s] && (i_slot_op[s] == OP_WRITE || is_load(i_slot_op[s]));
                wr_phys_reg[s] <= phys[s];
                mem_valid_reg[s] <= exe[s] && (is_load(i_slot_op[s]) || i_slot_op[s] == OP_ST);
                mem_store_reg[s] <= i_slot_op[s] == OP_ST;
                mem_hint_reg[s] <= i_slot_hint[s]; // [RULE_03]
                mem_addr_reg[s] <= i_slot_addr[s];
                if (exe[s] && i_slot_op[s] == OP_LD && i_slot_fault[s]) begin
                    fault_reg <= 1'b1;
                end
                // lowest failing slot wins the recovery report
                if ((exe[s] && i_slot_op[s] == OP_CHK_S && nat_reg[phys[s]]) || // [RULE_04]
                    (exe[s] && i_slot_op[s] == OP_CHK_A && // [RULE_05]
                     !(alat_v_reg[phys[s][`PSIC_ALAT_AW-1:0]] &&
                       alat_tag_reg[phys[s][`PSIC_ALAT_AW-1:0]] == phys[s]))) begin
                    recover_reg <= 1'b1;
                    recover_slot_reg <= 2'(s);
                end
            end
        end
    end

    // =========================================================================
    // register stack engine; stack ops are taken from slot 0 only
    psic_frame_mem u_frame_mem (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_we(exe[0] && i_slot_op[0] == OP_CALL),
        .i_waddr(fsp_reg),
        .i_wdata(sof_reg),
        .i_re(exe[0] && i_slot_op[0] == OP_RET),
        .i_raddr(fsp_reg - 1'b1),
        .o_rdata(fm_rdata)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_reg <= ST_IDLE;
            bof_reg <= '0;
            sof_reg <= '0;
            ndirty_reg <= '0;
            nspill_reg <= '0;
            fsp_reg <= '0;
            want_reg <= '0;
            prev_reg <= '0;
            rse_idx_reg <= '0;
            rse_req_reg <= 1'b0;
            rse_spill_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else if (i_ce) begin
            if (rse_req_reg && i_rse_ack) begin
                rse_req_reg <= 1'b0;
                ndirty_reg <= rse_spill_reg ? ndirty_reg - 1'b1 : ndirty_reg + 1'b1;
                nspill_reg <= rse_spill_reg ? nspill_reg + 1'b1 : nspill_reg - 1'b1;
                ready_reg <= st_reg == ST_IDLE;
            end
            unique case (st_reg)
                ST_IDLE: begin
                    if (rse_req_reg) begin
                        // background fill in flight, bundles held off
                    end else if (exe[0] && i_slot_op[0] == OP_ALLOC) begin
                        want_reg <= ({1'b0, i_slot_reg[0]} > `PSIC_STACK_GR) ?
                                    7'(`PSIC_STACK_GR) : i_slot_reg[0];
                        st_reg <= ST_ALLOC;
                        ready_reg <= 1'b0;
                    end else if (exe[0] && i_slot_op[0] == OP_CALL) begin
                        bof_reg <= wrap96(8'({1'b0, bof_reg} + {1'b0, sof_reg})); // [RULE_10]
                        ndirty_reg <= 7'(ndirty_reg + sof_reg);
                        sof_reg <= '0;
                        fsp_reg <= fsp_reg + 1'b1;
                    end else if (exe[0] && i_slot_op[0] == OP_RET) begin
                        fsp_reg <= fsp_reg - 1'b1;
                        st_reg <= ST_POP;
                        ready_reg <= 1'b0;
                    end else if (!accept && nspill_reg != '0 &&
                                 room > {1'b0, sof_reg}) begin
                        rse_req_reg <= 1'b1; // [RULE_14]
                        rse_spill_reg <= 1'b0;
                        rse_idx_reg <= 7'(`PSIC_STATIC_GR + wrap96(8'({1'b0, bof_reg} +
                                       `PSIC_STACK_GR - 8'h01 - {1'b0, ndirty_reg})));
                        ready_reg <= 1'b0;
                    end else begin
                        ready_reg <= 1'b1;
                    end
                end
                ST_ALLOC: begin
                    if (rse_req_reg) begin
                        // waiting on the spill in flight
                    end else if ({1'b0, want_reg} > room) begin
                        rse_req_reg <= 1'b1; // [RULE_11]
                        rse_spill_reg <= 1'b1;
                        rse_idx_reg <= 7'(`PSIC_STATIC_GR + wrap96(8'({1'b0, bof_reg} +
                                       `PSIC_STACK_GR - {1'b0, ndirty_reg})));
                    end else begin
                        sof_reg <= want_reg;
                        st_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
                ST_POP: begin
                    prev_reg <= fm_rdata;
                    st_reg <= ST_RET;
                end
                ST_RET: begin
                    if (rse_req_reg) begin
                        // waiting on the fill in flight
                    end else if (ndirty_reg < prev_reg && nspill_reg != '0) begin
                        rse_req_reg <= 1'b1; // [RULE_13]
                        rse_spill_reg <= 1'b0;
                        rse_idx_reg <= 7'(`PSIC_STATIC_GR + wrap96(8'({1'b0, bof_reg} +
                                       `PSIC_STACK_GR - 8'h01 - {1'b0, ndirty_reg})));
                    end else begin
                        bof_reg <= wrap96(8'({1'b0, bof_reg} + `PSIC_STACK_GR -
                                  {1'b0, prev_reg})); // [RULE_12]
                        ndirty_reg <= (ndirty_reg < prev_reg) ? '0 : ndirty_reg - prev_reg;
                        sof_reg <= prev_reg;
                        st_reg <= ST_IDLE;
                        ready_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    assign o_bnd_ready = ready_reg;
    assign o_pred = pred_reg;
    assign o_wr_valid = wr_valid_reg;
    assign o_wr_phys = wr_phys_reg;
    assign o_mem_valid = mem_valid_reg;
    assign o_mem_store = mem_store_reg;
    assign o_mem_hint = mem_hint_reg;
    assign o_mem_addr = mem_addr_reg;
    assign o_fault = fault_reg;
    assign o_recover = recover_reg;
    assign o_recover_slot = recover_slot_reg;
    assign o_rse_req = rse_req_reg;
    assign o_rse_spill = rse_spill_reg;
    assign o_rse_idx = rse_idx_reg;
    assign o_bof = bof_reg;
    assign o_sof = sof_reg;

    // =========================================================================
    // checks
    property p_pred_zero;
        @(posedge i_clk_sys) disable iff (i_rst) accept |=> o_pred[0] && $bits(o_pred) == 64;
    endproperty
    a_pred_zero: assert property (p_pred_zero) else $error("predicate zero lost"); // [RULE_01]
    property p_qp_false;
        @(posedge i_clk_sys) disable iff (i_rst)
            accept && !pred_reg[i_slot_qp[0]] |=> !o_wr_valid[0] && !o_mem_valid[0];
    endproperty
    a_qp_false: assert property (p_qp_false) else $error("false qualifier acted"); // [RULE_06]
    property p_cmp_pair;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[0] && i_slot_op[0] == OP_CMP && i_slot_p1[0] != 6'h00 && i_slot_p2[0] != 6'h00
            && i_slot_op[1] == OP_NOP && i_slot_op[2] == OP_NOP
            |=> o_pred[$past(i_slot_p1[0])] == $past(i_slot_cond[0])
                && o_pred[$past(i_slot_p2[0])] == !$past(i_slot_cond[0]);
    endproperty
    a_cmp_pair: assert property (p_cmp_pair) else $error("compare pair wrong"); // [RULE_07]
    property p_defer;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[0] && i_slot_op[0] == OP_LD_S && i_slot_fault[0]
            |=> !o_fault && nat_reg[$past(phys[0])];
    endproperty
    a_defer: assert property (p_defer) else $error("speculative fault not deferred"); // [RULE_04]
    property p_chk_a;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[0] && i_slot_op[0] == OP_CHK_A && !alat_v_reg[phys[0][1:0]]
            |=> o_recover && o_recover_slot == 2'h0;
    endproperty
    a_chk_a: assert property (p_chk_a) else $error("advanced check missed"); // [RULE_05]
    property p_hint;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[1] && is_load(i_slot_op[1]) |=> o_mem_valid[1] && o_mem_hint[1] == $past(i_slot_hint[1]);
    endproperty
    a_hint: assert property (p_hint) else $error("hint not carried"); // [RULE_03]
    property p_alloc_stall;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[0] && i_slot_op[0] == OP_ALLOC |=> !o_bnd_ready ##1 (st_reg == ST_IDLE || o_rse_req
            || {1'b0, want_reg} > room || !i_ce);
    endproperty
    a_alloc_stall: assert property (p_alloc_stall) else $error("alloc did not stall"); // [RULE_11]
    property p_call;
        @(posedge i_clk_sys) disable iff (i_rst)
            exe[0] && i_slot_op[0] == OP_CALL
            |=> o_sof == 7'h00 && o_bof == wrap96(8'({1'b0, $past(bof_reg)} + {1'b0, $past(sof_reg)}));
    endproperty
    a_call: assert property (p_call) else $error("call frame wrong"); // [RULE_10]
    property p_ret;
        @(posedge i_clk_sys) disable iff (i_rst)
            i_ce && st_reg == ST_RET && !rse_req_reg && !(ndirty_reg < prev_reg && nspill_reg != '0)
            |=> o_sof == $past(prev_reg) && o_bnd_ready;
    endproperty
    a_ret: assert property (p_ret) else $error("return not restored"); // [RULE_12]
    property p_underflow;
        @(posedge i_clk_sys) disable iff (i_rst)
            st_reg == ST_RET && ndirty_reg < prev_reg && nspill_reg != '0 |=> !o_bnd_ready;
    endproperty
    a_underflow: assert property (p_underflow) else $error("return ran early"); // [RULE_13]
endmodule : psic_core
`default_nettype wire

// ===== sim/psic_mem_model.sv
// psic_mem_model: memory side answering register stack spill and fill requests
`default_nettype none
module psic_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_req,
    input wire logic i_spill,
    input wire logic [6:0] i_idx,
    output logic o_ack,
    output var int o_n_spill,
    output var int o_n_fill,
    output var int o_first_idx
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] wait_reg;
    logic slow_reg;
    // ==========================================
    // answer
    // prompt and slow answers alternate so stalls of several lengths occur
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            wait_reg <= 2'h0;
            slow_reg <= 1'b0;
            o_n_spill <= 0;
            o_n_fill <= 0;
            o_first_idx <= -1;
        end else if (i_req && !o_ack && wait_reg == {slow_reg, 1'b0}) begin
            o_ack <= 1'b1;
            wait_reg <= 2'h0;
            slow_reg <= !slow_reg;
            if (i_spill) begin
                o_n_spill <= o_n_spill + 1;
                if (o_first_idx < 0) begin
                    o_first_idx <= int'(i_idx);
                end
            end else begin
                o_n_fill <= o_n_fill + 1;
            end
        end else begin
            o_ack <= 1'b0;
            if (i_req && !o_ack) begin
                wait_reg <= wait_reg + 2'h1;
            end
        end
    end
endmodule : psic_mem_model
`default_nettype wire

// ===== sim/tb_top.sv
// tb_top: bundle scenarios for the issue core
`default_nettype none
module tb_top import psic_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, ce = 1, vld = 0, ack, rdy, flt, rec, req, spl;
    psic_op_t op [3];
    logic [2:0][5:0] qp, p1, p2;
    logic [2:0][6:0] rg, wp;
    logic [2:0] cd, ft, wv, mv, ms;
    logic [2:0][1:0] ht, mh;
    logic [2:0][15:0] ad, ma;
    logic [63:0] pr;
    logic [1:0] rs;
    logic [6:0] idx, bof, sof;
    int mismatches = 0, n_tests = 0, ns, nf, fi;
    psic_core u_dut (.i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_bnd_valid(vld),
        .i_slot_op(op), .i_slot_qp(qp), .i_slot_p1(p1), .i_slot_p2(p2), .i_slot_reg(rg),
        .i_slot_cond(cd), .i_slot_fault(ft), .i_slot_hint(ht), .i_slot_addr(ad),
        .i_rse_ack(ack), .o_bnd_ready(rdy), .o_pred(pr), .o_wr_valid(wv), .o_wr_phys(wp),
        .o_mem_valid(mv), .o_mem_store(ms), .o_mem_hint(mh), .o_mem_addr(ma), .o_fault(flt),
        .o_recover(rec), .o_recover_slot(rs), .o_rse_req(req), .o_rse_spill(spl),
        .o_rse_idx(idx), .o_bof(bof), .o_sof(sof));
    psic_mem_model u_mem (.i_clk_sys(clk), .i_rst(rst), .i_req(req), .i_spill(spl),
        .i_idx(idx), .o_ack(ack), .o_n_spill(ns), .o_n_fill(nf), .o_first_idx(fi));
    initial forever #2 clk = ~clk;
    // ==========================================
    // helpers
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task sl(input int s, input psic_op_t o, input logic [5:0] q, a, b, input logic [6:0] r,
            input logic c, f, input logic [15:0] m);
        op[s] = o;
        qp[s] = q;
        p1[s] = a;
        p2[s] = b;
        rg[s] = r;
        cd[s] = c;
        ft[s] = f;
        ht[s] = ~2'(s);
        ad[s] = m;
    endtask : sl
    task wait_rdy;
        int k;
        k = 0;
        while (rdy !== 1'b1 && k < 3000) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 3000) chk("ready wait", 16'h0001, 16'h0000);
    endtask : wait_rdy
    // slots from n upward idle; outputs are judged in the cycle after the take
    task go(input int n);
        for (int s = n; s < 3; s++) op[s] = OP_NOP;
        @(posedge clk);
        #1;
        vld = 1;
        wait_rdy();
        @(posedge clk);
        #1;
        vld = 0;
    endtask : go
    // ==========================================
    // scenarios
    task t_cmp;
        sl(0, OP_CMP, 0, 3, 4, 0, 1, 0, 0);
        sl(1, OP_CMP, 0, 5, 6, 0, 0, 0, 0);
        sl(2, OP_CMP, 0, 6, 11, 0, 0, 0, 0);
        go(3);
        chk("pred 6..3", 16'h0001, 16'(pr[6:3]));
        chk("pred 11", 16'h0001, 16'(pr[11]));
        $display("t_cmp done");
    endtask : t_cmp
    task t_pred;
        sl(0, OP_CMP, 0, 10, 9, 0, 1, 0, 0);
        go(1);
        sl(0, OP_CMP, 9, 7, 8, 0, 0, 0, 0);
        sl(1, OP_CMP_UNC, 9, 10, 12, 0, 1, 0, 0);
        sl(2, OP_WRITE, 9, 0, 0, 7'h05, 0, 0, 0);
        go(3);
        chk("pred 12,10,8,7", 16'h0000, 16'({pr[12], pr[10], pr[8], pr[7]}));
        chk("wr valid", 16'h0000, 16'(wv));
        sl(0, OP_WRITE, 3, 0, 0, 7'h05, 0, 0, 0);
        go(1);
        chk("wr phys", 16'h0085, 16'({wv[0], wp[0]}));
        sl(0, OP_CMP_AND, 0, 3, 13, 0, 0, 0, 0);
        sl(1, OP_CMP_OR, 0, 7, 8, 0, 1, 0, 0);
        sl(2, OP_CMP_OR, 0, 10, 12, 0, 0, 0, 0);
        go(3);
        chk("pred 12,10,8,7,3", 16'h0006, 16'({pr[12], pr[10], pr[8], pr[7], pr[3]}));
        $display("t_pred done");
    endtask : t_pred
    task t_spec;
        sl(0, OP_LD_S, 0, 0, 0, 7'h05, 0, 1, 16'h0001);
        go(1);
        chk("spec fault", 16'h0000, 16'(flt));
        sl(0, OP_LD_S, 0, 0, 0, 7'h06, 0, 0, 16'h0003);
        sl(1, OP_LD, 0, 0, 0, 7'h07, 0, 1, 16'h0004);
        go(2);
        chk("ld fault", 16'h0001, 16'(flt));
        chk("ld req", 16'h000a, 16'({mv[1], ms[1], mh[1]}));
        chk("ld addr", 16'h0004, ma[1]);
        sl(0, OP_CHK_S, 0, 0, 0, 7'h06, 0, 0, 0);
        sl(1, OP_CHK_S, 0, 0, 0, 7'h05, 0, 0, 0);
        go(2);
        chk("chk_s recover", 16'h0005, 16'({rec, rs}));
        $display("t_spec done");
    endtask : t_spec
    task t_adv;
        sl(0, OP_LD_A, 0, 0, 0, 7'h08, 0, 0, 16'h0040);
        sl(1, OP_LD_A, 0, 0, 0, 7'h09, 0, 0, 16'h0050);
        go(2);
        sl(0, OP_ST, 0, 0, 0, 7'h01, 0, 0, 16'h0040);
        go(1);
        chk("st req", 16'h000f, 16'({mv[0], ms[0], mh[0]}));
        sl(0, OP_CHK_A, 0, 0, 0, 7'h09, 0, 0, 0);
        sl(1, OP_CHK_A, 0, 0, 0, 7'h08, 0, 0, 0);
        go(2);
        chk("chk_a recover", 16'h0005, 16'({rec, rs}));
        sl(0, OP_CHK_A, 0, 0, 0, 7'h08, 0, 0, 0);
        go(1);
        chk("chk_a slot 0", 16'h0004, 16'({rec, rs}));
        $display("t_adv done");
    endtask : t_adv
    task t_frame;
        sl(0, OP_ALLOC, 0, 0, 0, 7'h0a, 0, 0, 0);
        go(1);
        wait_rdy();
        chk("sof alloc", 16'h000a, 16'(sof));
        sl(0, OP_WRITE, 0, 0, 0, 7'h22, 0, 0, 0);
        go(1);
        chk("phys caller", 16'h0022, 16'(wp[0]));
        sl(0, OP_CALL, 0, 0, 0, 0, 0, 0, 0);
        go(1);
        chk("bof,sof call", 16'h0a00, 16'({1'b0, bof, 1'b0, sof}));
        sl(0, OP_ALLOC, 0, 0, 0, 7'h60, 0, 0, 0);
        go(1);
        wait_rdy();
        chk("spills", 16'h000a, ns[15:0]);
        chk("first spill", 16'h0020, fi[15:0]);
        chk("sof big", 16'h0060, 16'(sof));
        // a smaller frame leaves room, so idle cycles fill back six registers
        sl(0, OP_ALLOC, 0, 0, 0, 7'h5a, 0, 0, 0);
        go(1);
        wait_rdy();
        repeat (40) @(posedge clk);
        #1;
        chk("bg fills", 16'h0006, nf[15:0]);
        sl(0, OP_WRITE, 0, 0, 0, 7'h21, 0, 0, 0);
        go(1);
        chk("phys callee", 16'h002b, 16'(wp[0]));
        sl(0, OP_RET, 0, 0, 0, 0, 0, 0, 0);
        go(1);
        wait_rdy();
        chk("bof,sof ret", 16'h000a, 16'({1'b0, bof, 1'b0, sof}));
        chk("fills", 16'h000a, nf[15:0]);
        $display("t_frame done");
    endtask : t_frame
    task final_report;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    initial begin
        #100000;
        mismatches++;
        final_report();
    end
    initial begin
        for (int s = 0; s < 3; s++) sl(s, OP_NOP, 0, 0, 0, 0, 0, 0, 0);
        repeat (4) @(posedge clk);
        #1;
        rst = 0;
        t_cmp();
        t_pred();
        t_spec();
        t_adv();
        t_frame();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
